// ### bench/pcb_agent_bench.sv
// Purpose: Self-checking bench for the agent acting as bus master and as memory target
// Assumes: Peer model is the target for the agent's master cycles; the bench itself drives the agent's target side
// Notes: Released AD toggles each cycle so stale data cannot pass
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module pcb_agent_bench
	import pcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ADR = 32'h0040_1230;
	localparam logic [31:0] RDB = 32'hA5C3_0000;
	localparam logic [31:0] TGA = 32'h0000_0120;
	logic [31:0] b_ad, t_rdata;
	logic [3:0] b_cbe_n;
	logic b_ad_oe_n, b_cbe_oe_n, b_frame_n, b_irdy_n, t_ready, t_start, t_busy, t_rtake, t_wvalid;
	pcb_hdr_s t_hdr;
	pcb_word_s t_word;
	logic i_clock, i_srst, i_req_valid, i_stop_n, p_stop_en, bad, stp, seen, adon_p;
	pcb_req_s i_req;
	pcb_word_s i_mst_word;
	pcb_word_s wds[4];
	logic [31:0] rd[4];
	logic [31:0] o_ad, p_ad, ad_w, ad_p, o_mst_rdata;
	logic [3:0] o_cbe_n, cbe_w, cbe_p;
	logic o_ad_oe_n, o_cbe_oe_n, o_par, o_par_oe_n, p_par, p_par_oe_n, par_w;
	logic o_frame_n, o_frame_oe_n, o_irdy_n, o_irdy_oe_n, o_trdy_n, o_trdy_oe_n;
	logic p_ad_oe_n, p_trdy_n, p_trdy_oe_n, frame_w, irdy_w, trdy_w;
	logic o_req_ready, o_req_bad, o_mst_take, o_mst_rvalid, o_mst_done, o_mst_stopped;
	logic [2:0] p_wait;
	int errors, cmp_count, wi, rn, fc;

	// Bench itself acts as a second master to reach the agent's target side
	assign ad_w = !o_ad_oe_n ? o_ad : (!p_ad_oe_n ? p_ad : (!b_ad_oe_n ? b_ad : ~ad_p));
	assign cbe_w = !o_cbe_oe_n ? o_cbe_n : (!b_cbe_oe_n ? b_cbe_n : 4'hF);
	assign frame_w = (o_frame_oe_n | o_frame_n) & b_frame_n;
	assign irdy_w = (o_irdy_oe_n | o_irdy_n) & b_irdy_n;
	assign trdy_w = (o_trdy_oe_n | o_trdy_n) & (p_trdy_oe_n | p_trdy_n);
	assign par_w = !o_par_oe_n ? o_par : p_par;

	pcb_agent i_pcb_agent (.i_clock(i_clock), .i_srst(i_srst), .i_ad(ad_w), .o_ad(o_ad),
		.o_ad_oe_n(o_ad_oe_n), .i_cbe_n(cbe_w), .o_cbe_n(o_cbe_n), .o_cbe_oe_n(o_cbe_oe_n),
		.o_par(o_par), .o_par_oe_n(o_par_oe_n), .i_frame_n(frame_w), .o_frame_n(o_frame_n),
		.o_frame_oe_n(o_frame_oe_n), .i_irdy_n(irdy_w), .o_irdy_n(o_irdy_n), .o_irdy_oe_n(o_irdy_oe_n),
		.i_trdy_n(trdy_w), .o_trdy_n(o_trdy_n), .o_trdy_oe_n(o_trdy_oe_n), .i_stop_n(i_stop_n),
		.i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_req_bad(o_req_bad),
		.i_mst_word(i_mst_word), .o_mst_take(o_mst_take), .o_mst_rdata(o_mst_rdata),
		.o_mst_rvalid(o_mst_rvalid), .o_mst_done(o_mst_done), .o_mst_stopped(o_mst_stopped),
		.o_tgt_hdr(t_hdr), .o_tgt_start(t_start), .o_tgt_busy(t_busy), .i_tgt_ready(t_ready),
		.i_tgt_rdata(t_rdata), .o_tgt_rtake(t_rtake), .o_tgt_word(t_word), .o_tgt_wvalid(t_wvalid));

	pcb_peer i_pcb_peer (.i_clock(i_clock), .i_srst(i_srst), .i_ad(ad_w), .i_cbe_n(cbe_w),
		.i_frame_n(frame_w), .i_irdy_n(irdy_w), .i_wait(p_wait), .i_stop_en(p_stop_en), .o_ad(p_ad),
		.o_ad_oe_n(p_ad_oe_n), .o_par(p_par), .o_par_oe_n(p_par_oe_n), .o_trdy_n(p_trdy_n),
		.o_trdy_oe_n(p_trdy_oe_n), .o_stop_n(i_stop_n));

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	always @(negedge i_clock) begin
		if (!i_srst && adon_p && !(o_par_oe_n && p_par_oe_n))
			`CHK(par_w, ^{ad_p, cbe_p})
		if (!i_srst)
			`CHK(o_ad_oe_n | p_ad_oe_n, 1'b1)
		ad_p = ad_w;
		cbe_p = cbe_w;
		adon_p = !(o_ad_oe_n & p_ad_oe_n);
	end

	task automatic xfer(input logic [3:0] c, input logic [7:0] n);
		int k;
		wi = 0;
		rn = 0;
		fc = 0;
		bad = 1'b0;
		stp = 1'b0;
		seen = 1'b0;
		@(negedge i_clock);
		i_req = '{cmd: c, addr: ADR, words: n};
		i_req_valid = 1'b1;
		i_mst_word = wds[0];
		for (k = 0; k < 300; k++) begin
			@(posedge i_clock);
			#1;
			if (!frame_w && !seen) begin
				seen = 1'b1;
				`CHK(ad_w, ADR)
				`CHK(cbe_w, c)
			end
			if (!i_stop_n && !frame_w)
				fc++;
			if (o_mst_rvalid) begin
				rd[rn % 4] = o_mst_rdata;
				rn++;
			end
			if (o_mst_take)
				wi++;
			bad |= o_req_bad;
			stp |= o_mst_stopped;
			if (o_mst_done || bad)
				break;
			@(negedge i_clock);
			if (!o_req_ready)
				i_req_valid = 1'b0;
			i_mst_word = wds[wi % 4];
		end
		`CHK(k < 300, 1'b1)
		@(negedge i_clock);
		i_req_valid = 1'b0;
		// Let a late refusal pulse drain before the next request
		repeat (3) @(negedge i_clock);
	endtask : xfer

	task automatic t_write();
		wds[0] = '{32'h1122_3344, 4'h0};
		wds[1] = '{32'h5566_7788, 4'hA};
		wds[2] = '{32'h99AA_BBCC, 4'h3};
		p_wait = 3'h1;
		xfer(4'h7, 8'h03);
		`CHK(i_pcb_peer.n_q, 8'h03)
		for (int i = 0; i < 3; i++) begin
			`CHK(i_pcb_peer.cap[i], wds[i])
			`CHK(i_pcb_peer.fr_cap[i], i == 2)
		end
	endtask : t_write

	task automatic t_read();
		p_wait = 3'h2;
		xfer(4'h6, 8'h02);
		`CHK(rn, 2)
		for (int i = 0; i < 2; i++) begin
			`CHK(rd[i], RDB + i)
			`CHK(i_pcb_peer.cap[i].be_n, wds[i].be_n)
		end
	endtask : t_read

	task automatic t_codes();
		logic rsv;
		p_wait = 3'h0;
		for (int c = 0; c < 16; c++) begin
			rsv = c inside {4, 5, 8, 9, 13};
			xfer(c[3:0], 8'h01);
			`CHK(bad, rsv)
			`CHK(seen, !rsv)
		end
	endtask : t_codes

	task automatic t_stop();
		p_stop_en = 1'b1;
		xfer(4'h7, 8'h04);
		`CHK(stp, 1'b1)
		`CHK(fc <= 3, 1'b1)
		`CHK(i_pcb_peer.n_q, 8'h00)
		p_stop_en = 1'b0;
	endtask : t_stop

	// One-word cycle from the bench as master; peer waits long enough to stay out of it
	task automatic t_target(input logic [3:0] c, input logic [31:0] d);
		int k;
		p_wait = 3'h6;
		t_ready = 1'b1;
		t_rdata = d;
		@(negedge i_clock);
		b_ad = TGA;
		b_ad_oe_n = 1'b0;
		b_cbe_n = c;
		b_cbe_oe_n = 1'b0;
		b_frame_n = 1'b0;
		@(negedge i_clock);
		`CHK(t_start, 1'b1)
		`CHK(t_busy, 1'b1)
		`CHK(t_hdr, {c, TGA})
		b_frame_n = 1'b1;
		b_irdy_n = 1'b0;
		b_ad = d;
		b_ad_oe_n = !c[0];
		b_cbe_n = 4'h5;
		for (k = 0; k < 8 && trdy_w; k++)
			@(negedge i_clock);
		`CHK(k < 8, 1'b1)
		if (!c[0])
			`CHK(ad_w, d)
		@(negedge i_clock);
		`CHK(t_wvalid, c[0])
		`CHK(t_rtake, !c[0])
		if (c[0])
			`CHK(t_word, {d, 4'h5})
		b_irdy_n = 1'b1;
		b_ad_oe_n = 1'b1;
		b_cbe_oe_n = 1'b1;
		repeat (3) @(negedge i_clock);
		`CHK(t_busy, 1'b0)
		t_ready = 1'b0;
	endtask : t_target

	task automatic conclude();
		$display("Errors %0d in %0d compares", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude

	initial begin
		i_srst = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		i_mst_word = '0;
		p_wait = 3'h0;
		p_stop_en = 1'b0;
		b_ad = 32'h0000_0000;
		b_cbe_n = 4'hF;
		b_ad_oe_n = 1'b1;
		b_cbe_oe_n = 1'b1;
		b_frame_n = 1'b1;
		b_irdy_n = 1'b1;
		t_ready = 1'b0;
		t_rdata = 32'h0000_0000;
		errors = 0;
		cmp_count = 0;
		repeat (16) @(negedge i_clock);
		i_srst = 1'b0;
		t_write();
		t_read();
		t_codes();
		t_stop();
		t_target(4'h7, 32'h1357_9BDF);
		t_target(4'h6, 32'h2468_ACE0);
		conclude();
	end

	initial begin
		#40000;
		errors++;
		conclude();
	end
endmodule : pcb_agent_bench

`default_nettype wire

// ### bench/pcb_peer.sv
// Purpose: Far-side target model answering the agent's master cycles
// Assumes: Bus inputs are the resolved wire levels
// Notes: Read data counts up so every word is distinct
`default_nettype none

module pcb_peer
	import pcb_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [31:0] i_ad,
	input wire logic [3:0] i_cbe_n,
	input wire logic i_frame_n,
	input wire logic i_irdy_n,
	input wire logic [2:0] i_wait,
	input wire logic i_stop_en,
	output logic [31:0] o_ad,
	output logic o_ad_oe_n,
	output logic o_par,
	output logic o_par_oe_n,
	output logic o_trdy_n,
	output logic o_trdy_oe_n,
	output logic o_stop_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic act_q, rd_q, fr_q;
	logic [2:0] wc_q;
	logic [7:0] n_q;
	pcb_word_s cap[16];
	logic fr_cap[16];

	always @(posedge i_clock) begin
		fr_q <= i_frame_n;
		// Parity trails the data it covers by one clock
		o_par <= ^{o_ad, i_cbe_n};
		o_par_oe_n <= o_ad_oe_n;
		if (i_srst) begin
			act_q <= 1'b0;
			rd_q <= 1'b0;
			wc_q <= 3'h0;
			n_q <= 8'h00;
			o_ad <= 32'h0000_0000;
			o_ad_oe_n <= 1'b1;
			o_trdy_n <= 1'b1;
			o_trdy_oe_n <= 1'b1;
			o_stop_n <= 1'b1;
		end else if (!act_q) begin
			o_trdy_oe_n <= !fr_q | i_frame_n;
			if (fr_q && !i_frame_n) begin
				act_q <= 1'b1;
				rd_q <= !i_cbe_n[0];
				// Reads spend one more clock on the turnaround
				wc_q <= i_wait + {2'h0, !i_cbe_n[0]};
				n_q <= 8'h00;
			end
		end else if (!i_irdy_n && !o_trdy_n) begin
			cap[n_q] <= '{i_ad, i_cbe_n};
			fr_cap[n_q] <= i_frame_n;
			n_q <= n_q + 8'h01;
			o_trdy_n <= 1'b1;
			o_ad_oe_n <= 1'b1;
			wc_q <= i_wait;
			act_q <= !i_frame_n;
		end else if (i_frame_n && i_irdy_n) begin
			act_q <= 1'b0;
			o_stop_n <= 1'b1;
		end else if (i_stop_en) begin
			o_stop_n <= 1'b0;
		end else if (wc_q != 3'h0) begin
			wc_q <= wc_q - 3'h1;
		end else begin
			o_trdy_n <= 1'b0;
			o_ad_oe_n <= !rd_q;
			o_ad <= 32'hA5C3_0000 + {24'h00_0000, n_q};
		end
	end
endmodule : pcb_peer

`default_nettype wire

// ### rtl/pcb_agent.sv
// Purpose: Bus agent issuing transactions as master and answering memory cycles as target
// Assumes: i_clock is the bus_clock itself, so bus inputs are sampled directly; grant is held
// Notes: Device select, retry, abort and arbitration live in other blocks
`include "pcb_params.svh"
`default_nettype none

module pcb_agent
	import pcb_pkg::*;
#(
	parameter logic [31:0] TGT_BASE = `PCB_TGT_BASE,
	parameter logic [31:0] TGT_MASK = `PCB_TGT_MASK
) (
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [31:0] i_ad,
	output logic [31:0] o_ad,
	output logic o_ad_oe_n,
	input wire logic [3:0] i_cbe_n,
	output logic [3:0] o_cbe_n,
	output logic o_cbe_oe_n,
	output logic o_par,
	output logic o_par_oe_n,
	input wire logic i_frame_n,
	output logic o_frame_n,
	output logic o_frame_oe_n,
	input wire logic i_irdy_n,
	output logic o_irdy_n,
	output logic o_irdy_oe_n,
	input wire logic i_trdy_n,
	output logic o_trdy_n,
	output logic o_trdy_oe_n,
	input wire logic i_stop_n,
	input wire logic i_req_valid,
	input wire pcb_req_s i_req,
	output logic o_req_ready,
	output logic o_req_bad,
	input wire pcb_word_s i_mst_word,
	output logic o_mst_take,
	output logic [31:0] o_mst_rdata,
	output logic o_mst_rvalid,
	output logic o_mst_done,
	output logic o_mst_stopped,
	output pcb_hdr_s o_tgt_hdr,
	output logic o_tgt_start,
	output logic o_tgt_busy,
	input wire logic i_tgt_ready,
	input wire logic [31:0] i_tgt_rdata,
	output logic o_tgt_rtake,
	output pcb_word_s o_tgt_word,
	output logic o_tgt_wvalid
);

	localparam int WW = `PCB_WORDS_W;

	function automatic logic cmd_legal(input logic [3:0] cmd);
		case (cmd)
			`PCB_CMD_RSV4, `PCB_CMD_RSV5, `PCB_CMD_RSV8, `PCB_CMD_RSV9, `PCB_CMD_DAC: cmd_legal = 1'b0;
			default: cmd_legal = 1'b1;
		endcase
	endfunction : cmd_legal

	function automatic logic cmd_is_write(input logic [3:0] cmd);
		case (cmd)
			`PCB_CMD_IOWR, `PCB_CMD_MWR, `PCB_CMD_MWI, `PCB_CMD_CFGWR, `PCB_CMD_SPEC: cmd_is_write = 1'b1;
			default: cmd_is_write = 1'b0;
		endcase
	endfunction : cmd_is_write

	function automatic logic cmd_is_mem(input logic [3:0] cmd);
		case (cmd)
			`PCB_CMD_MRD, `PCB_CMD_MWR, `PCB_CMD_MRDM: cmd_is_mem = 1'b1;
			`PCB_CMD_MRDL, `PCB_CMD_MWI: cmd_is_mem = 1'b1;
			default: cmd_is_mem = 1'b0;
		endcase
	endfunction : cmd_is_mem

	pcb_mst_e mst_q;
	pcb_tgt_e tgt_q;
	logic [WW-1:0] remain_q;
	logic wr_q;
	logic stopped_q;
	logic trd_q;
	logic frame_prev_q;
	logic [3:0] cbe_bus;
	logic m_go;
	logic m_xfer;
	logic m_end;
	logic m_load;
	logic t_start;
	logic t_xfer;
	logic t_quit;
	logic t_give;

	// Lines we do not drive carry the other master's command or enables
	assign cbe_bus = o_cbe_oe_n ? i_cbe_n : o_cbe_n;
	assign m_go = (mst_q == M_IDLE) && o_req_ready && i_req_valid && cmd_legal(i_req.cmd)
		&& (tgt_q == T_IDLE) && i_frame_n && i_irdy_n;
	assign m_xfer = (mst_q == M_DATA) && !o_irdy_n && !i_trdy_n;
	assign m_end = (mst_q == M_DATA) && o_frame_n && (m_xfer || !i_stop_n);
	assign m_load = (mst_q == M_ADDR) || (m_xfer && !m_end);
	assign t_start = (tgt_q == T_IDLE) && (mst_q == M_IDLE) && frame_prev_q && !i_frame_n && i_irdy_n
		&& cmd_is_mem(i_cbe_n) && ((i_ad & TGT_MASK) == TGT_BASE);
	assign t_xfer = (tgt_q == T_DATA) && !o_trdy_n && !i_irdy_n;
	assign t_quit = (tgt_q == T_DATA) && i_frame_n && (t_xfer || i_irdy_n);
	assign t_give = (tgt_q == T_DATA) && o_trdy_n && i_tgt_ready && !t_quit;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			frame_prev_q <= 1'b1;
		end else begin
			frame_prev_q <= i_frame_n;
		end
	end

	// Master framing; no target answer means the master waits, abort is handled elsewhere
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			mst_q <= M_IDLE;
			remain_q <= '0;
			wr_q <= 1'b0;
			stopped_q <= 1'b0;
			o_frame_n <= 1'b1;
			o_frame_oe_n <= 1'b1;
			o_irdy_n <= 1'b1;
			o_irdy_oe_n <= 1'b1;
			o_cbe_n <= `PCB_BE_NONE;
			o_cbe_oe_n <= 1'b1;
			o_req_ready <= 1'b1;
		end else begin
			case (mst_q)
				M_IDLE: begin
					if (m_go) begin
						mst_q <= M_ADDR;
						o_req_ready <= 1'b0;
						wr_q <= cmd_is_write(i_req.cmd);
						remain_q <= (i_req.words == '0) ? WW'(1) : i_req.words;
						stopped_q <= 1'b0;
						o_frame_n <= 1'b0;
						o_frame_oe_n <= 1'b0;
						o_cbe_n <= i_req.cmd;
						o_cbe_oe_n <= 1'b0;
					end
				end
				M_ADDR: begin
					mst_q <= M_DATA;
					o_irdy_n <= 1'b0;
					o_irdy_oe_n <= 1'b0;
					o_cbe_n <= i_mst_word.be_n;
					o_frame_n <= (remain_q == WW'(1));
				end
				M_DATA: begin
					if (m_end) begin
						mst_q <= M_TURN;
						o_irdy_n <= 1'b1;
						o_cbe_oe_n <= 1'b1;
					end else begin
						if (!i_stop_n) begin
							o_frame_n <= 1'b1;
							stopped_q <= 1'b1;
						end
						if (m_xfer) begin
							remain_q <= remain_q - WW'(1);
							o_cbe_n <= i_mst_word.be_n;
							if (remain_q <= WW'(2)) begin
								o_frame_n <= 1'b1;
							end
						end
					end
				end
				M_TURN: begin
					// Drive high for one clock before release so the pull-up is not relied on
					mst_q <= M_IDLE;
					o_frame_oe_n <= 1'b1;
					o_irdy_oe_n <= 1'b1;
					o_req_ready <= 1'b1;
				end
				default: mst_q <= M_IDLE;
			endcase
		end
	end

	// Target answers one word per two clocks; the idle clock after each word keeps TRDY# simple
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			tgt_q <= T_IDLE;
			trd_q <= 1'b0;
			o_trdy_n <= 1'b1;
			o_trdy_oe_n <= 1'b1;
			o_tgt_hdr <= '0;
		end else begin
			case (tgt_q)
				T_IDLE: begin
					if (t_start) begin
						o_tgt_hdr <= '{cmd: i_cbe_n, addr: i_ad};
						trd_q <= !cmd_is_write(i_cbe_n);
						tgt_q <= cmd_is_write(i_cbe_n) ? T_DATA : T_TA;
						o_trdy_oe_n <= 1'b0;
					end
				end
				T_TA: tgt_q <= T_DATA;
				T_DATA: begin
					if (t_quit) begin
						tgt_q <= T_END;
						o_trdy_n <= 1'b1;
					end else if (t_give) begin
						o_trdy_n <= 1'b0;
					end else if (t_xfer) begin
						o_trdy_n <= 1'b1;
					end
				end
				T_END: begin
					tgt_q <= T_IDLE;
					o_trdy_oe_n <= 1'b1;
				end
				default: tgt_q <= T_IDLE;
			endcase
		end
	end

	// Shared AD drivers; master and target phases never overlap
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_ad <= '0;
			o_ad_oe_n <= 1'b1;
		end else if (m_go) begin
			o_ad <= i_req.addr;
			o_ad_oe_n <= 1'b0;
		end else if (mst_q == M_ADDR) begin
			if (wr_q) begin
				o_ad <= i_mst_word.data;
			end else begin
				o_ad_oe_n <= 1'b1;
			end
		end else if (m_end) begin
			o_ad_oe_n <= 1'b1;
		end else if (m_xfer && wr_q) begin
			o_ad <= i_mst_word.data;
		end else if (t_give && trd_q) begin
			o_ad <= i_tgt_rdata;
			o_ad_oe_n <= 1'b0;
		end else if (t_quit) begin
			o_ad_oe_n <= 1'b1;
		end
	end

	// Parity trails AD by one clock, so it holds one clock past each completed phase
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_par <= 1'b0;
			o_par_oe_n <= 1'b1;
		end else begin
			o_par <= ^{o_ad, cbe_bus};
			o_par_oe_n <= o_ad_oe_n;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_req_bad <= 1'b0;
			o_mst_take <= 1'b0;
			o_mst_rdata <= '0;
			o_mst_rvalid <= 1'b0;
			o_mst_done <= 1'b0;
			o_mst_stopped <= 1'b0;
			o_tgt_start <= 1'b0;
			o_tgt_busy <= 1'b0;
			o_tgt_rtake <= 1'b0;
			o_tgt_word <= '0;
			o_tgt_wvalid <= 1'b0;
		end else begin
			o_req_bad <= (mst_q == M_IDLE) && o_req_ready && i_req_valid && !cmd_legal(i_req.cmd);
			o_mst_take <= m_load;
			o_mst_rvalid <= m_xfer && !wr_q;
			if (m_xfer && !wr_q) begin
				o_mst_rdata <= i_ad;
			end
			o_mst_done <= m_end;
			o_mst_stopped <= m_end && (stopped_q || !i_stop_n);
			o_tgt_start <= t_start;
			o_tgt_busy <= t_start || (tgt_q == T_TA) || ((tgt_q == T_DATA) && !t_quit);
			o_tgt_rtake <= t_xfer && trd_q;
			o_tgt_wvalid <= t_xfer && !trd_q;
			if (t_xfer && !trd_q) begin
				o_tgt_word <= '{data: i_ad, be_n: i_cbe_n};
			end
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	a_stop_frame: assert property ((mst_q == M_DATA) && !i_stop_n && !o_frame_n |=> o_frame_n)
		else $error("FRAME# not released after STOP#");
	a_addr_phase: assert property ((mst_q == M_ADDR) |-> !o_frame_n && !o_ad_oe_n && !o_cbe_oe_n
		&& (o_ad == $past(i_req.addr)) && (o_cbe_n == $past(i_req.cmd)))
		else $error("address phase not driven with address and command");
	a_first_data: assert property ($rose(mst_q == M_ADDR) |=> (mst_q == M_DATA) && !o_irdy_n)
		else $error("address phase not followed by a data phase");
	a_par_even: assert property (!$past(o_ad_oe_n) |-> (o_par ^ (^{$past(o_ad), $past(cbe_bus)})) == 1'b0)
		else $error("parity not even over previous AD and C/BE");
	a_par_delay: assert property ($fell(o_ad_oe_n) |=> !o_par_oe_n ##1 $stable(o_par_oe_n) or $rose(o_par_oe_n))
		else $error("PAR enable does not trail AD enable by one clock");
	a_par_hold: assert property ((m_end && wr_q) |=> !o_par_oe_n)
		else $error("write parity dropped at phase completion");
	a_wr_stable: assert property ((mst_q == M_DATA) && wr_q && !o_irdy_n && i_trdy_n && i_stop_n && !m_end
		|=> $stable(o_ad) && $stable(o_cbe_n))
		else $error("write data or enables moved during wait");
	a_tgt_read: assert property (trd_q && (tgt_q == T_DATA) && !o_trdy_n |-> !o_ad_oe_n)
		else $error("TRDY# asserted without read data on AD");
	a_last_frame: assert property ((mst_q == M_DATA) && o_frame_n |-> (remain_q <= WW'(1)) || stopped_q)
		else $error("FRAME# released before final data phase");
	a_rd_pulse: assert property (o_mst_rvalid |-> $past(!o_irdy_n && !i_trdy_n && (mst_q == M_DATA)))
		else $error("read word taken without both ready");
	a_tgt_frame: assert property ((tgt_q != T_IDLE) |-> o_frame_oe_n)
		else $error("FRAME# driven while acting as target");

	c_write_burst: cover property (o_mst_done && !o_mst_stopped && wr_q);
	c_read_done: cover property ((mst_q == M_DATA) && !wr_q ##1 o_mst_rvalid);
	c_stopped: cover property (o_mst_stopped);
	c_tgt_write: cover property (o_tgt_wvalid ##[1:8] o_tgt_wvalid);

endmodule : pcb_agent

`default_nettype wire

// ### rtl/pcb_params.svh
// Purpose: Constants for the bus-phase signalling block
// Assumes: Command values are the code carried on the four command/byte-enable lines
// Notes: Included by the package and by the agent
`ifndef PCB_PARAMS_SVH
`define PCB_PARAMS_SVH

`define PCB_CMD_INTA 4'h0
`define PCB_CMD_SPEC 4'h1
`define PCB_CMD_IORD 4'h2
`define PCB_CMD_IOWR 4'h3
`define PCB_CMD_RSV4 4'h4
`define PCB_CMD_RSV5 4'h5
`define PCB_CMD_MRD 4'h6
`define PCB_CMD_MWR 4'h7
`define PCB_CMD_RSV8 4'h8
`define PCB_CMD_RSV9 4'h9
`define PCB_CMD_CFGRD 4'hA
`define PCB_CMD_CFGWR 4'hB
`define PCB_CMD_MRDM 4'hC
`define PCB_CMD_DAC 4'hD
`define PCB_CMD_MRDL 4'hE
`define PCB_CMD_MWI 4'hF

`define PCB_BE_NONE 4'hF
`define PCB_STOP_LIMIT 3
`define PCB_WORDS_W 8
`define PCB_TGT_BASE 32'h0000_0000
`define PCB_TGT_MASK 32'hFFFF_0000

`endif

// ### rtl/pcb_pkg.sv
// Purpose: Types shared by the bus-phase signalling block
// Assumes: Constants come from pcb_params.svh
// Notes: Structs carry request and data words as units
`include "pcb_params.svh"
`default_nettype none

package pcb_pkg;
	typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pcb_mst_e;
	typedef enum logic [1:0] {T_IDLE, T_TA, T_DATA, T_END} pcb_tgt_e;
	typedef struct packed {
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [`PCB_WORDS_W-1:0] words;
	} pcb_req_s;
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] be_n;
	} pcb_word_s;
	typedef struct packed {
		logic [3:0] cmd;
		logic [31:0] addr;
	} pcb_hdr_s;
endpackage : pcb_pkg

`default_nettype wire
